// ==== inc/step_pkg.sv ====
package step_pkg;
  // widths
  localparam int CNT_W = 24;
  localparam int SPD_W = 13;
  localparam int MUL_W = 10;
  localparam int ACC_W = 10;
  localparam int ENV_W = 3;
  localparam int MODE_W = 4;
  localparam int PW_W = 5;

  // byte port offsets within one axis
  localparam logic [1:0] OFS_CMD = 2'h0;
  localparam logic [1:0] OFS_DATA_LO = 2'h1;
  localparam logic [1:0] OFS_DATA_MID = 2'h2;
  localparam logic [1:0] OFS_DATA_HI = 2'h3;

  // command opcodes, upper nibble of a command byte
  localparam logic [3:0] OP_SELECT = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_START = 4'h2;
  localparam logic [3:0] OP_SLOW_STOP = 4'h3;
  localparam logic [3:0] OP_FAST_STOP = 4'h4;
  localparam logic [3:0] OP_HOLD = 4'h5;
  localparam logic [3:0] OP_CONTINUE = 4'h6;
  localparam logic [3:0] OP_MODE = 4'h7;

  // register indices, low three bits of select and load commands
  localparam logic [2:0] REG_COUNT = 3'h0;
  localparam logic [2:0] REG_START = 3'h1;
  localparam logic [2:0] REG_TOP = 3'h2;
  localparam logic [2:0] REG_ACCEL = 3'h3;
  localparam logic [2:0] REG_MULT = 3'h4;
  localparam logic [2:0] REG_ENV = 3'h7;

  // output mode bits (low nibble of OP_MODE)
  localparam int MODE_HIGH = 0;
  localparam int MODE_PRESET = 1;
  localparam int MODE_INHIBIT = 2;
  localparam int MODE_CCW = 3;

  // environment register bits
  localparam int ENV_PULSE_DIR = 0;
  localparam int ENV_SCURVE = 1;
  localparam int ENV_INT_EN = 2;

  // status byte bits
  localparam int STS_BUSY = 0;
  localparam int STS_HOLD = 1;
  localparam int STS_RAMP_UP = 2;
  localparam int STS_RAMP_DN = 3;
  localparam int STS_INT = 4;
  localparam int STS_ZERO = 5;

  // reset values
  localparam logic [SPD_W-1:0] RST_START = 13'h0001;
  localparam logic [SPD_W-1:0] RST_TOP = 13'h0064;
  localparam logic [ACC_W-1:0] RST_ACCEL = 10'h00A;
  localparam logic [MUL_W-1:0] RST_MULT = 10'h258;
  localparam logic [MODE_W-1:0] RST_MODE = 4'h0;
  localparam logic [ENV_W-1:0] RST_ENV = 3'h0;

  // rate generation: ref clock and divisor 8192
  localparam logic [26:0] CLK_HZ = 27'h5F5E100;
  localparam logic [26:0] REF_HZ = 27'h4B0000;
  localparam int RATE_SHIFT = 13;

  // step pulse width, least time rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_NS = 200;
  localparam logic [PW_W-1:0] PULSE_CYC = PW_W'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    MS_IDLE = 4'b0001,
    MS_RUN = 4'b0010,
    MS_DECEL = 4'b0100,
    MS_PAUSE = 4'b1000
  } motion_state_type;
endpackage

// ==== verilog/step_rate_gen.sv ====
`timescale 1ns/1ps
module step_rate_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // rate request
  input wire logic run,
  input wire logic [step_pkg::SPD_W-1:0] speed,
  input wire logic [step_pkg::MUL_W-1:0] mult,
  // strobes
  output logic ref_tick,
  output logic step
);
  import step_pkg::*;

  logic [26:0] ref_acc_ff;
  logic [27:0] nxt_ref_sum;
  logic [23:0] phase_ff;
  logic [23:0] nxt_phase_sum;
  logic [23:0] limit;
  logic ref_tick_ff;
  logic step_ff;

  // fractional divider keeps the mean reference rate exact
  assign nxt_ref_sum = {1'b0, ref_acc_ff} + {1'b0, REF_HZ};
  assign limit = 24'(mult) << RATE_SHIFT;
  assign nxt_phase_sum = phase_ff + {11'h000, speed};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_acc_ff <= 27'h0000000;
      ref_tick_ff <= 1'b0;
    end else if (nxt_ref_sum >= {1'b0, CLK_HZ}) begin
      ref_acc_ff <= 27'(nxt_ref_sum - {1'b0, CLK_HZ});
      ref_tick_ff <= 1'b1;
    end else begin
      ref_acc_ff <= nxt_ref_sum[26:0];
      ref_tick_ff <= 1'b0;
    end
  end

  // step rate = speed * ref / (8192 * mult)
  always_ff @(posedge core_clk) begin
    if (!rst_n || !run) begin
      phase_ff <= 24'h000000;
      step_ff <= 1'b0;
    end else if (ref_tick_ff && nxt_phase_sum >= limit) begin
      phase_ff <= nxt_phase_sum - limit;
      step_ff <= 1'b1;
    end else if (ref_tick_ff) begin
      phase_ff <= nxt_phase_sum;
      step_ff <= 1'b0;
    end else begin
      step_ff <= 1'b0;
    end
  end

  assign ref_tick = ref_tick_ff;
  assign step = step_ff;
endmodule

// ==== verilog/step_pulse_preset_counter.sv ====
`timescale 1ns/1ps
module step_pulse_preset_counter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // axis byte port
  input wire logic [1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // external stop pin
  input wire logic ext_stop_n,
  // motor driver
  output logic out_a,
  output logic out_b,
  output logic int_req,
  output logic busy
);
  import step_pkg::*;

  function automatic logic is_op(input logic [7:0] b, input logic [3:0] op);
    return b[7:4] == op;
  endfunction

  motion_state_type state_ff;
  motion_state_type nxt_state;

  logic stop_s1_ff;
  logic stop_s2_ff;
  logic [CNT_W-1:0] data_ff;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] rbuf_ff;
  logic [SPD_W-1:0] start_ff;
  logic [SPD_W-1:0] top_ff;
  logic [ACC_W-1:0] accel_ff;
  logic [MUL_W-1:0] mult_ff;
  logic [ENV_W-1:0] env_ff;
  logic [MODE_W-1:0] mode_ff;
  logic [SPD_W-1:0] cur_ff;
  logic [ACC_W:0] ramp_cnt_ff;
  logic [PW_W-1:0] pw_cnt_ff;
  logic int_ff;
  logic out_a_ff;
  logic out_b_ff;
  logic [7:0] rdata_ff;

  logic cmd_wr;
  logic moving;
  logic ext_stop;
  logic gen_tick;
  logic gen_step;
  logic step_w;
  logic start_cmd;
  logic zero_start;
  logic fast_stop;
  logic slow_stop;
  logic preset_done;
  logic ramp_tick;
  logic near_end;
  logic [SPD_W-1:0] span;
  logic [ACC_W:0] ramp_period;
  logic [SPD_W-1:0] target;
  logic [7:0] status;

  assign cmd_wr = bus_wr && bus_addr == OFS_CMD;
  assign moving = state_ff == MS_RUN || state_ff == MS_DECEL;
  assign ext_stop = !stop_s2_ff;
  // late steps from the generator are dropped once the run ends
  assign step_w = gen_step && moving;

  assign start_cmd = cmd_wr && is_op(bus_wdata, OP_START) && state_ff == MS_IDLE;
  assign zero_start = start_cmd && mode_ff[MODE_PRESET] && count_ff == 24'h000000;
  assign fast_stop = (cmd_wr && is_op(bus_wdata, OP_FAST_STOP)) || ext_stop;
  assign slow_stop = cmd_wr && is_op(bus_wdata, OP_SLOW_STOP);
  // last counted pulse of a positioning run
  assign preset_done = step_w && mode_ff[MODE_PRESET] && !mode_ff[MODE_INHIBIT]
                       && count_ff == 24'h000001;

  // external stop pin synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stop_s1_ff <= 1'b1;
      stop_s2_ff <= 1'b1;
    end else begin
      stop_s1_ff <= ext_stop_n;
      stop_s2_ff <= stop_s1_ff;
    end
  end

  // data byte staging
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      data_ff <= 24'h000000;
    end else if (bus_wr) begin
      case (bus_addr)
        OFS_DATA_LO: data_ff[7:0] <= bus_wdata;
        OFS_DATA_MID: data_ff[15:8] <= bus_wdata;
        OFS_DATA_HI: data_ff[23:16] <= bus_wdata;
        default: data_ff <= data_ff;
      endcase
    end
  end

  // setting registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_ff <= RST_START;
      top_ff <= RST_TOP;
      accel_ff <= RST_ACCEL;
      mult_ff <= RST_MULT;
      env_ff <= RST_ENV;
    end else if (cmd_wr && is_op(bus_wdata, OP_LOAD)) begin
      case (bus_wdata[2:0])
        REG_START: start_ff <= data_ff[SPD_W-1:0];
        REG_TOP: top_ff <= data_ff[SPD_W-1:0];
        REG_ACCEL: accel_ff <= data_ff[ACC_W-1:0];
        REG_MULT: mult_ff <= data_ff[MUL_W-1:0];
        REG_ENV: env_ff <= data_ff[ENV_W-1:0];
        default: env_ff <= env_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_ff <= RST_MODE;
    end else if (cmd_wr && is_op(bus_wdata, OP_MODE) && state_ff == MS_IDLE) begin
      mode_ff <= bus_wdata[MODE_W-1:0];
    end
  end

  // remaining-pulse counter; loads only while idle so a run never sees a jump
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_ff <= 24'h000000;
    end else if (cmd_wr && is_op(bus_wdata, OP_LOAD) && bus_wdata[2:0] == REG_COUNT
                 && state_ff == MS_IDLE) begin
      count_ff <= data_ff;
    end else if (step_w && !mode_ff[MODE_INHIBIT]) begin
      count_ff <= count_ff - 24'h000001;
    end
  end

  // read snapshot taken at select time
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rbuf_ff <= 24'h000000;
    end else if (cmd_wr && is_op(bus_wdata, OP_SELECT) && bus_wdata[2:0] == REG_COUNT) begin
      rbuf_ff <= count_ff;
    end
  end

  // motion sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MS_IDLE: begin
        if (start_cmd && !zero_start && !ext_stop) begin
          nxt_state = MS_RUN;
        end
      end
      MS_RUN: begin
        if (fast_stop || preset_done) begin
          nxt_state = MS_IDLE;
        end else if (slow_stop) begin
          nxt_state = mode_ff[MODE_HIGH] ? MS_DECEL : MS_IDLE;
        end else if (cmd_wr && is_op(bus_wdata, OP_HOLD)) begin
          nxt_state = MS_PAUSE;
        end
      end
      MS_DECEL: begin
        if (fast_stop || preset_done || cur_ff <= start_ff) begin
          nxt_state = MS_IDLE;
        end
      end
      MS_PAUSE: begin
        if (fast_stop || slow_stop) begin
          nxt_state = MS_IDLE;
        end else if (cmd_wr && is_op(bus_wdata, OP_CONTINUE)) begin
          nxt_state = MS_RUN;
        end
      end
      default: nxt_state = MS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= MS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ramp pacing; S-curve slows the rate of change near both ends
  assign span = top_ff - start_ff;
  assign near_end = (cur_ff - start_ff) < (span >> 3) || (top_ff - cur_ff) < (span >> 3);
  assign ramp_period = (env_ff[ENV_SCURVE] && near_end) ? {accel_ff, 1'b0}
                                                         : {1'b0, accel_ff};
  assign ramp_tick = gen_tick && ramp_cnt_ff + 11'h001 >= ramp_period;
  assign target = mode_ff[MODE_HIGH] ? top_ff : start_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !moving || ramp_tick) begin
      ramp_cnt_ff <= 11'h000;
    end else if (gen_tick) begin
      ramp_cnt_ff <= ramp_cnt_ff + 11'h001;
    end
  end

  // current speed
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ff <= RST_START;
    end else if (!moving) begin
      cur_ff <= start_ff;
    end else if (state_ff == MS_DECEL) begin
      if (ramp_tick && cur_ff > start_ff) begin
        cur_ff <= cur_ff - 13'h0001;
      end
    end else if (!mode_ff[MODE_HIGH]) begin
      cur_ff <= start_ff;
    end else if (ramp_tick && cur_ff < target) begin
      cur_ff <= cur_ff + 13'h0001;
    end else if (ramp_tick && cur_ff > target) begin
      cur_ff <= cur_ff - 13'h0001;
    end
  end

  step_rate_gen u_rate (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(moving),
    .speed(cur_ff),
    .mult(mult_ff),
    .ref_tick(gen_tick),
    .step(gen_step)
  );

  // step pulse shaping
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pw_cnt_ff <= 5'h00;
    end else if (step_w) begin
      pw_cnt_ff <= PULSE_CYC;
    end else if (pw_cnt_ff != 5'h00) begin
      pw_cnt_ff <= pw_cnt_ff - 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else if (env_ff[ENV_PULSE_DIR]) begin
      out_a_ff <= pw_cnt_ff != 5'h00;
      out_b_ff <= mode_ff[MODE_CCW];
    end else begin
      out_a_ff <= pw_cnt_ff != 5'h00 && !mode_ff[MODE_CCW];
      out_b_ff <= pw_cnt_ff != 5'h00 && mode_ff[MODE_CCW];
    end
  end

  // interrupt: set wins over the clear by the next command
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= (zero_start && env_ff[ENV_INT_EN]) || (int_ff && !cmd_wr);
    end
  end

  // status and read data
  always_comb begin
    status = 8'h00;
    status[STS_BUSY] = moving;
    status[STS_HOLD] = state_ff == MS_PAUSE;
    status[STS_RAMP_UP] = state_ff == MS_RUN && cur_ff < target;
    status[STS_RAMP_DN] = state_ff == MS_DECEL || (state_ff == MS_RUN && cur_ff > target);
    status[STS_INT] = int_ff;
    status[STS_ZERO] = count_ff == 24'h000000;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      case (bus_addr)
        OFS_CMD: rdata_ff <= status;
        OFS_DATA_LO: rdata_ff <= rbuf_ff[7:0];
        OFS_DATA_MID: rdata_ff <= rbuf_ff[15:8];
        OFS_DATA_HI: rdata_ff <= rbuf_ff[23:16];
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign bus_rdata = rdata_ff;
  assign out_a = out_a_ff;
  assign out_b = out_b_ff;
  assign int_req = int_ff;
  assign busy = moving;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_count_step: assert property (
    step_w && !mode_ff[MODE_INHIBIT] |=> count_ff == $past(count_ff) - 24'h000001)
    else $error("counter did not decrement on a step");

  chk_count_inhibit: assert property (
    step_w && mode_ff[MODE_INHIBIT] |=> count_ff == $past(count_ff))
    else $error("inhibited counter changed");

  chk_snapshot_take: assert property (
    cmd_wr && is_op(bus_wdata, OP_SELECT) && bus_wdata[2:0] == REG_COUNT
    |=> rbuf_ff == $past(count_ff) ##2 $past(bus_addr) != OFS_DATA_LO
    || bus_rdata == $past(rbuf_ff[7:0]))
    else $error("read snapshot wrong");

  chk_preset_end: assert property (
    preset_done |=> state_ff == MS_IDLE && count_ff == 24'h000000 ##1 !gen_step || !busy)
    else $error("positioning did not end at zero");

  chk_zero_start: assert property (
    zero_start |=> state_ff == MS_IDLE [*3])
    else $error("zero-count start moved");

  chk_zero_int: assert property (
    zero_start && env_ff[ENV_INT_EN] |=> int_req)
    else $error("zero-count start gave no interrupt");

  chk_stop_keep: assert property (
    moving && fast_stop && !step_w |=> state_ff == MS_IDLE && $stable(count_ff))
    else $error("stop lost the remaining count");

  chk_decel_floor: assert property (
    state_ff == MS_DECEL && cur_ff <= start_ff |=> state_ff == MS_IDLE)
    else $error("decelerating stop overran start speed");

  // a step on the very edge that enters the pause may still count, so look one cycle on
  chk_hold_quiet: assert property (
    state_ff == MS_PAUSE |-> !step_w ##1 $stable(count_ff))
    else $error("step during hold");

  chk_pulse_width: assert property (
    step_w |=> ##1 (out_a || out_b) [*8])
    else $error("step pulse too short");
endmodule

// ==== testbench/step_motor_driver_model.sv ====
`timescale 1ns/1ps
module step_motor_driver_model (
  // clock
  input wire logic core_clk,
  // pulse lines from the block
  input wire logic out_a,
  input wire logic out_b,
  // format and count clear
  input wire logic fmt,
  input wire logic clr,
  // observed motion
  output int cw_steps,
  output int ccw_steps,
  output int last_gap
);
  logic prev_a = 1'b0;
  logic prev_b = 1'b0;
  int gap = 0;
  logic seen = 1'b0;

  // counts on rising edges only, so a stretched pulse is still one step
  always @(posedge core_clk) begin
    prev_a <= out_a;
    prev_b <= out_b;
    gap <= gap + 1;
    if (clr) begin
      cw_steps <= 0;
      ccw_steps <= 0;
      seen <= 1'b0;
    end else if (out_a && !prev_a) begin
      if (fmt && out_b) begin
        ccw_steps <= ccw_steps + 1;
      end else begin
        cw_steps <= cw_steps + 1;
      end
      if (seen) begin
        last_gap <= gap;
      end
      seen <= 1'b1;
      gap <= 1;
    end else if (!fmt && out_b && !prev_b) begin
      ccw_steps <= ccw_steps + 1;
    end
  end
endmodule

// ==== testbench/test_step_pulse_preset_counter.sv ====
`timescale 1ns/1ps
module test_step_pulse_preset_counter;
  import step_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] bus_addr = 2'h0;
  logic bus_wr = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic ext_stop_n = 1'b1;
  logic out_a, out_b, int_req, busy;
  logic fmt = 1'b0;
  logic clr = 1'b0;
  int cw_steps, ccw_steps, last_gap;
  int miscompares = 0;
  int tests_run = 0;

  always #5 core_clk = ~core_clk;

  step_pulse_preset_counter dut (
    .core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ext_stop_n(ext_stop_n),
    .out_a(out_a), .out_b(out_b), .int_req(int_req), .busy(busy)
  );

  step_motor_driver_model drv (
    .core_clk(core_clk), .out_a(out_a), .out_b(out_b), .fmt(fmt), .clr(clr),
    .cw_steps(cw_steps), .ccw_steps(ccw_steps), .last_gap(last_gap)
  );

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 d = bus_rdata;
  endtask

  task automatic cmd(input logic [3:0] op, input logic [3:0] arg);
    wr(OFS_CMD, {op, arg});
  endtask

  task automatic load(input logic [2:0] idx, input logic [23:0] v);
    wr(OFS_DATA_LO, v[7:0]);
    wr(OFS_DATA_MID, v[15:8]);
    wr(OFS_DATA_HI, v[23:16]);
    cmd(OP_LOAD, {1'b0, idx});
  endtask

  task automatic read_count(output logic [23:0] v);
    logic [7:0] b;
    cmd(OP_SELECT, {1'b0, REG_COUNT});
    rd(OFS_DATA_LO, b);
    v[7:0] = b;
    rd(OFS_DATA_MID, b);
    v[15:8] = b;
    rd(OFS_DATA_HI, b);
    v[23:16] = b;
  endtask

  task automatic zero_model;
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
  endtask

  // last pulse is 2 cycles behind its step and 20 wide, so settle after busy falls
  task automatic wait_idle;
    int k;
    k = 0;
    @(posedge core_clk);
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge core_clk);
      k++;
    end
    check("idle in time", 24'(k < 20000), 24'h1);
    repeat (30) @(posedge core_clk);
  endtask

  task automatic wait_steps(input int n);
    int k;
    k = 0;
    while (cw_steps + ccw_steps < n && k < 20000) begin
      @(posedge core_clk);
      k++;
    end
    check("steps in time", 24'(k < 20000), 24'h1);
  endtask

  task automatic t_reset;
    logic [7:0] s;
    logic [23:0] v;
    rd(OFS_CMD, s);
    check("status after reset", {16'h0, s & 8'h21}, 24'h000020);
    read_count(v);
    check("count after reset", v, 24'h000000);
    load(REG_COUNT, 24'hFFFFFF);
    read_count(v);
    check("count full scale", v, 24'hFFFFFF);
  endtask

  task automatic t_preset;
    logic [23:0] v;
    int m;
    load(REG_START, 24'h001FFF);
    load(REG_ENV, 24'h000000);
    cmd(OP_MODE, 4'h2);
    for (m = 2; m <= 4; m += 2) begin
      load(REG_MULT, 24'(m));
      load(REG_COUNT, 24'h000005);
      zero_model();
      cmd(OP_START, 4'h0);
      wait_idle();
      check("preset steps", 24'(cw_steps), 24'h000005);
      read_count(v);
      check("count after run", v, 24'h000000);
      check("step gap", 24'(last_gap >= 20 * m - 1 && last_gap <= 21 * m), 24'h1);
    end
  endtask

  task automatic t_stop_resume;
    logic [23:0] v;
    int c;
    load(REG_COUNT, 24'h00000C);
    zero_model();
    cmd(OP_START, 4'h0);
    wait_steps(3);
    c = cw_steps;
    read_count(v);
    check("read while moving", 24'(v <= 24'(12 - c) && v >= 24'(11 - c)), 24'h1);
    cmd(OP_FAST_STOP, 4'h0);
    wait_idle();
    read_count(v);
    check("kept after stop", v, 24'(12 - cw_steps));
    cmd(OP_START, 4'h0);
    wait_steps(cw_steps + 2);
    ext_stop_n <= 1'b0;
    wait_idle();
    ext_stop_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    read_count(v);
    check("kept after pin stop", v, 24'(12 - cw_steps));
    cmd(OP_START, 4'h0);
    wait_idle();
    check("resumed total", 24'(cw_steps), 24'h00000C);
  endtask

  task automatic t_hold;
    logic [7:0] s;
    int n;
    load(REG_COUNT, 24'h000006);
    zero_model();
    cmd(OP_START, 4'h0);
    wait_steps(2);
    cmd(OP_HOLD, 4'h0);
    repeat (30) @(posedge core_clk);
    rd(OFS_CMD, s);
    check("hold flag", {23'h0, s[STS_HOLD]}, 24'h1);
    n = cw_steps;
    repeat (300) @(posedge core_clk);
    check("no steps in hold", 24'(cw_steps), 24'(n));
    cmd(OP_CONTINUE, 4'h0);
    wait_idle();
    check("steps after continue", 24'(cw_steps), 24'h000006);
  endtask

  task automatic t_inhibit;
    logic [23:0] v;
    cmd(OP_MODE, 4'h6);
    load(REG_COUNT, 24'h000003);
    zero_model();
    cmd(OP_START, 4'h0);
    wait_steps(5);
    cmd(OP_FAST_STOP, 4'h0);
    wait_idle();
    read_count(v);
    check("count inhibited", v, 24'h000003);
  endtask

  task automatic t_format;
    int f;
    cmd(OP_MODE, 4'hA);
    for (f = 0; f < 2; f++) begin
      load(REG_ENV, 24'(f));
      fmt <= f[0];
      load(REG_COUNT, 24'h000003);
      zero_model();
      cmd(OP_START, 4'h0);
      wait_idle();
      check("ccw steps", 24'(ccw_steps), 24'h000003);
      check("cw steps", 24'(cw_steps), 24'h000000);
    end
  endtask

  // span of 16 units, two ref ticks per unit; s-curve doubles the outer units
  task automatic t_ramp;
    logic [7:0] s;
    int f;
    int k;
    load(REG_START, 24'h001000);
    load(REG_TOP, 24'h001010);
    load(REG_ACCEL, 24'h000002);
    load(REG_MULT, 24'h000002);
    cmd(OP_MODE, 4'h1);
    for (f = 0; f < 2; f++) begin
      load(REG_ENV, 24'(f * 2));
      cmd(OP_START, 4'h0);
      rd(OFS_CMD, s);
      check("ramp up flag", {23'h0, s[STS_RAMP_UP]}, 24'h1);
      repeat (1200) @(posedge core_clk);
      rd(OFS_CMD, s);
      check("at top rate", {16'h0, s & 8'h0D}, 24'h000001);
      cmd(OP_SLOW_STOP, 4'h0);
      k = 0;
      while (busy === 1'b1 && k < 2000) begin
        @(posedge core_clk);
        k++;
      end
      check("decel time", 24'(f == 0 ? (k >= 600 && k <= 675) : (k >= 680 && k <= 800)), 24'h1);
    end
    cmd(OP_START, 4'h0);
    repeat (1200) @(posedge core_clk);
    load(REG_TOP, 24'h001008);
    rd(OFS_CMD, s);
    check("new top ramps down", {23'h0, s[STS_RAMP_DN]}, 24'h1);
    check("no stop on new top", {23'h0, busy}, 24'h1);
    repeat (600) @(posedge core_clk);
    rd(OFS_CMD, s);
    check("settled at new top", {16'h0, s & 8'h0D}, 24'h000001);
    cmd(OP_FAST_STOP, 4'h0);
    @(posedge core_clk);
    check("immediate stop", {23'h0, busy}, 24'h0);
  endtask

  task automatic t_zero;
    load(REG_ENV, 24'h000004);
    fmt <= 1'b0;
    cmd(OP_MODE, 4'h2);
    load(REG_COUNT, 24'h000000);
    zero_model();
    cmd(OP_START, 4'h0);
    repeat (40) @(posedge core_clk);
    check("no run on zero", {23'h0, busy}, 24'h0);
    check("no steps on zero", 24'(cw_steps), 24'h0);
    check("int on zero", {23'h0, int_req}, 24'h1);
    cmd(OP_SELECT, 4'h0);
    repeat (2) @(posedge core_clk);
    check("int cleared", {23'h0, int_req}, 24'h0);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_preset();
    t_stop_resume();
    t_hold();
    t_inhibit();
    t_format();
    t_ramp();
    t_zero();
    tally_and_finish();
  end

  // all scenarios need well under 20k cycles
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
endmodule
